//--- common/vector_map_pkg.sv
// constants for the reset entry point and the two vector tables
// assumes a 24-bit word-addressed program space, two address units per word
package vector_map_pkg;
    localparam int ADDR_W = 24;
    localparam logic [23:0] RESET_ADDR = 24'h000000;
    localparam logic [23:0] JUMP_TARGET_ADDR = 24'h000002;
    localparam logic [23:0] RESERVED_ADDR = 24'h000004;
    localparam logic [23:0] PRIMARY_BASE = 24'h000000;
    localparam logic [23:0] ALTERNATE_BASE = 24'h000100;
    localparam logic [23:0] TRAP_OFFSET = 24'h000006;
    localparam logic [23:0] IRQ_OFFSET = 24'h000014;
    localparam logic [23:0] PRIMARY_IRQ_LAST = 24'h0000FE;
    localparam logic [23:0] ALTERNATE_IRQ_FIRST = 24'h000114;
    localparam logic [23:0] ALTERNATE_IRQ_LAST = 24'h0001FE;
    localparam logic [23:0] USER_CODE_ADDR = 24'h000200;
    localparam int NUM_TRAPS = 5;
    localparam int NUM_IRQS = 118;
    localparam logic [6:0] IRQ_MAX = 7'h75;
    localparam logic [2:0] TRAP_MAX = 3'h4;
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_FETCH = 2'b01,
        ST_LOAD = 2'b10
    } vec_state_t;
endpackage

//--- logic/reset_vector_unit.sv
// program counter start-up and vector fetch sequencing for traps and interrupts
// assumes the core drives one-cycle accept pulses and a one-cycle program read answer
`timescale 1ns/10ps
// Functional notes
// - any reset clears state and sets the program counter to zero
// - first fetch after reset comes from address zero
// - reset uses no vector lookup and involves no interrupt logic
// - after a reserved word come five trap vectors then two reserved words
// - primary interrupt vector n sits at 0x14 plus twice n
// - alternate table repeats the layout at 0x100; user code at 0x200
// - lower table address gives higher natural priority
// - select bit chooses the alternate table for every vector
// - each vector word holds a 24-bit handler address loaded into the counter
module reset_vector_unit (
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic [4:0] I_TRAP_PENDING,
    input wire logic [117:0] I_IRQ_PENDING,
    input wire logic I_ACCEPT,
    input wire logic I_ALTERNATE_TABLE_SELECT,
    input wire logic I_ADVANCE,
    input wire logic [23:0] I_NEXT_PC,
    input wire logic [23:0] I_READ_DATA,
    input wire logic I_READ_VALID,
    output logic [23:0] O_PROGRAM_COUNTER,
    output logic O_READ_REQ,
    output logic [23:0] O_READ_ADDR,
    output logic O_TAKEN,
    output logic [6:0] O_TAKEN_INDEX,
    output logic O_BUSY
);
    localparam int NSRC = vector_map_pkg::NUM_TRAPS + vector_map_pkg::NUM_IRQS;

    vector_map_pkg::vec_state_t state, next_state;
    logic [23:0] pc, next_pc;
    logic [23:0] addr, next_addr;
    logic [6:0] idx, next_idx;
    logic taken, next_taken;
    logic any_pending;
    logic [6:0] win_index;

    // word address of source k (traps 0..4, then irq 0..117) in a table
    function automatic logic [23:0] vector_addr(input logic alt, input logic [6:0] k);
        logic [23:0] base;
        logic [23:0] off;
        base = alt ? vector_map_pkg::ALTERNATE_BASE : vector_map_pkg::PRIMARY_BASE;
        if (k <= 7'(vector_map_pkg::TRAP_MAX))
            off = vector_map_pkg::TRAP_OFFSET + {16'h0000, k, 1'b0};
        else
            off = vector_map_pkg::IRQ_OFFSET
                + {16'h0000, 7'(k - 7'(vector_map_pkg::NUM_TRAPS)), 1'b0};
        return base + off;
    endfunction

    vector_select #(
        .N(NSRC)
    ) u_select (
        .i_pending({I_IRQ_PENDING, I_TRAP_PENDING}),
        .o_any(any_pending),
        .o_index(win_index)
    );

    always_comb begin
        next_state = state;
        next_pc = pc;
        next_addr = addr;
        next_idx = idx;
        next_taken = 1'b0;
        case (state)
            vector_map_pkg::ST_RUN: begin
                if (I_ACCEPT && any_pending) begin
                    next_idx = win_index;
                    next_addr = vector_addr(I_ALTERNATE_TABLE_SELECT, win_index);
                    next_state = vector_map_pkg::ST_FETCH;
                end else if (I_ADVANCE) begin
                    next_pc = I_NEXT_PC;
                end
            end
            vector_map_pkg::ST_FETCH: begin
                next_state = vector_map_pkg::ST_LOAD;
            end
            vector_map_pkg::ST_LOAD: begin
                if (I_READ_VALID) begin
                    next_pc = I_READ_DATA;
                    next_taken = 1'b1;
                    next_state = vector_map_pkg::ST_RUN;
                end
            end
            default: begin
                next_state = vector_map_pkg::ST_RUN;
            end
        endcase
    end

    // reset goes straight to address zero with no table read
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            state <= vector_map_pkg::ST_RUN;
            pc <= vector_map_pkg::RESET_ADDR;
            addr <= vector_map_pkg::RESET_ADDR;
            idx <= 7'h00;
            taken <= 1'b0;
        end else begin
            state <= next_state;
            pc <= next_pc;
            addr <= next_addr;
            idx <= next_idx;
            taken <= next_taken;
        end
    end

    assign O_PROGRAM_COUNTER = pc;
    assign O_READ_ADDR = addr;
    assign O_READ_REQ = (state == vector_map_pkg::ST_FETCH);
    assign O_TAKEN = taken;
    assign O_TAKEN_INDEX = idx;
    assign O_BUSY = (state != vector_map_pkg::ST_RUN);

    chk_reset_pc_zero: assert property (@(posedge I_CLK) $fell(I_RST) |->
        O_PROGRAM_COUNTER == vector_map_pkg::RESET_ADDR)
        else $error("program counter not zero after reset");
    chk_reset_no_fetch: assert property (@(posedge I_CLK) $fell(I_RST) |->
        !O_READ_REQ && !O_BUSY)
        else $error("vector activity right after reset");
    chk_reset_no_vector: assert property (@(posedge I_CLK) disable iff (I_RST)
        O_READ_REQ |-> $past(O_BUSY) || $past(I_ACCEPT))
        else $error("vector read without accept");
    chk_trap_layout: assert property (@(posedge I_CLK) disable iff (I_RST)
        O_READ_REQ && O_TAKEN_INDEX <= 7'(vector_map_pkg::TRAP_MAX) |->
        O_READ_ADDR[7:0] == 8'(vector_map_pkg::TRAP_OFFSET) + {O_TAKEN_INDEX, 1'b0})
        else $error("trap vector address wrong");
    chk_irq_range: assert property (@(posedge I_CLK) disable iff (I_RST)
        O_READ_REQ && O_TAKEN_INDEX > 7'(vector_map_pkg::TRAP_MAX) |->
        O_READ_ADDR[7:0] >= 8'(vector_map_pkg::IRQ_OFFSET)
        && O_READ_ADDR < vector_map_pkg::USER_CODE_ADDR)
        else $error("interrupt vector address out of table");
    chk_table_select: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_ACCEPT && !O_BUSY && (|{I_IRQ_PENDING, I_TRAP_PENDING}) |=> O_READ_REQ
        && O_READ_ADDR[8] == $past(I_ALTERNATE_TABLE_SELECT))
        else $error("table select not honoured");
    chk_priority_low: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_ACCEPT && !O_BUSY && I_TRAP_PENDING[0] |=> O_TAKEN_INDEX == 7'h00)
        else $error("lowest address did not win");
    chk_handler_load: assert property (@(posedge I_CLK) disable iff (I_RST)
        O_BUSY && !O_READ_REQ && I_READ_VALID |=>
        O_TAKEN && O_PROGRAM_COUNTER == $past(I_READ_DATA))
        else $error("handler address not loaded");
    // exact interrupt slot, not only its range
    chk_irq_slot: assert property (@(posedge I_CLK) disable iff (I_RST)
        O_READ_REQ && O_TAKEN_INDEX > 7'(vector_map_pkg::TRAP_MAX) |->
        O_READ_ADDR[7:0] == 8'(vector_map_pkg::IRQ_OFFSET)
        + {O_TAKEN_INDEX - 7'(vector_map_pkg::NUM_TRAPS), 1'b0})
        else $error("interrupt vector slot wrong");
    chk_primary_top: assert property (@(posedge I_CLK) disable iff (I_RST)
        O_READ_REQ && !O_READ_ADDR[8] |->
        O_READ_ADDR <= vector_map_pkg::PRIMARY_IRQ_LAST)
        else $error("primary vector past table end");
    chk_alt_irq_start: assert property (@(posedge I_CLK) disable iff (I_RST)
        O_READ_REQ && O_READ_ADDR[8] && O_TAKEN_INDEX > 7'(vector_map_pkg::TRAP_MAX) |->
        O_READ_ADDR >= vector_map_pkg::ALTERNATE_IRQ_FIRST
        && O_READ_ADDR <= vector_map_pkg::ALTERNATE_IRQ_LAST)
        else $error("alternate interrupt vector out of table");
    // the reserved word at 0x04 and the reset words are never fetched as vectors
    chk_reserved_skip: assert property (@(posedge I_CLK) disable iff (I_RST)
        O_READ_REQ |->
        O_READ_ADDR[7:0] != 8'(vector_map_pkg::RESERVED_ADDR)
        && O_READ_ADDR[7:0] != 8'(vector_map_pkg::RESET_ADDR)
        && O_READ_ADDR[7:0] != 8'(vector_map_pkg::JUMP_TARGET_ADDR))
        else $error("reserved word used as vector");
    chk_trap_first: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_ACCEPT && !O_BUSY && (|I_TRAP_PENDING) |=>
        O_TAKEN_INDEX <= 7'(vector_map_pkg::TRAP_MAX))
        else $error("interrupt beat a pending trap");
    chk_fetch_once: assert property (@(posedge I_CLK) disable iff (I_RST)
        O_READ_REQ |=> O_BUSY && !O_READ_REQ)
        else $error("vector read not a single request");
    chk_taken_pulse: assert property (@(posedge I_CLK) disable iff (I_RST)
        O_TAKEN |=> !O_TAKEN)
        else $error("taken strobe longer than one cycle");
    // counter must not move while a vector is in flight
    chk_pc_hold_busy: assert property (@(posedge I_CLK) disable iff (I_RST)
        O_BUSY && !(I_READ_VALID && !O_READ_REQ) |=>
        O_PROGRAM_COUNTER == $past(O_PROGRAM_COUNTER))
        else $error("counter moved during vector fetch");
    chk_taken_idle: assert property (@(posedge I_CLK) disable iff (I_RST)
        O_TAKEN |-> !O_BUSY)
        else $error("taken while still busy");
    cov_trap: cover property (@(posedge I_CLK) O_TAKEN && O_TAKEN_INDEX < 7'h05);
    cov_primary_irq: cover property (@(posedge I_CLK)
        O_READ_REQ && !O_READ_ADDR[8] && O_TAKEN_INDEX > 7'h04);
    cov_slow_answer: cover property (@(posedge I_CLK)
        O_BUSY && !O_READ_REQ && !I_READ_VALID);
    cov_alt: cover property (@(posedge I_CLK) O_READ_REQ && O_READ_ADDR[8]);
    cov_last_irq: cover property (@(posedge I_CLK)
        O_READ_REQ && O_READ_ADDR == vector_map_pkg::ALTERNATE_IRQ_LAST);
endmodule // reset_vector_unit

//--- logic/vector_select.sv
// picks the winning pending source by natural priority
// assumes pending vectors arrive as a flat bit vector, traps first
`timescale 1ns/10ps
module vector_select #(
    parameter int N = 123
) (
    input wire logic [N-1:0] i_pending,
    output logic o_any,
    output logic [6:0] o_index
);
    // lowest index means lowest address, so it wins
    always_comb begin
        o_any = 1'b0;
        o_index = 7'h00;
        for (int k = N - 1; k >= 0; k--) begin
            if (i_pending[k]) begin
                o_any = 1'b1;
                o_index = 7'(k);
            end
        end
    end
endmodule // vector_select

//--- verif/testbench.sv
// self-checking bench for the reset entry and vector fetch unit
// assumes vector_memory answers every read with address xor a fixed pattern
`timescale 1ns/10ps
module testbench;
    logic I_CLK = 1'b0;
    logic I_RST = 1'b1;
    logic [4:0] trap = 5'h00;
    logic [117:0] irq = '0;
    logic acc = 1'b0;
    logic alt = 1'b0;
    logic adv = 1'b0;
    logic [23:0] npc = 24'h000000;
    logic [1:0] dly = 2'h0;
    logic rvalid, rreq, taken, busy;
    logic [23:0] rdata, pc, raddr;
    logic [6:0] tidx;
    logic [54:0] n;
    logic [127:0] p;
    logic [23:0] ea;
    logic [54:0] notes[$];
    int err_total = 0;
    int checks = 0;
    int seed = 32'he14e1318;
    int w, k;
    always #5 I_CLK = ~I_CLK;
    reset_vector_unit reset_vector_unit_i (.I_CLK(I_CLK), .I_RST(I_RST),
        .I_TRAP_PENDING(trap), .I_IRQ_PENDING(irq), .I_ACCEPT(acc),
        .I_ALTERNATE_TABLE_SELECT(alt), .I_ADVANCE(adv), .I_NEXT_PC(npc),
        .I_READ_DATA(rdata), .I_READ_VALID(rvalid), .O_PROGRAM_COUNTER(pc),
        .O_READ_REQ(rreq), .O_READ_ADDR(raddr), .O_TAKEN(taken),
        .O_TAKEN_INDEX(tidx), .O_BUSY(busy));
    vector_memory vector_memory_i (.i_clk(I_CLK), .i_req(rreq), .i_addr(raddr),
        .i_delay(dly), .o_valid(rvalid), .o_data(rdata));
    task automatic cmp(input string what, input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge I_CLK) begin
        #1;
        if (taken === 1'b1) begin
            n = (notes.size() > 0) ? notes.pop_front() : '1;
            cmp("index", {17'h0, tidx}, {17'h0, n[54:48]});
            cmp("vector address", raddr, n[47:24]);
            cmp("handler", pc, n[23:0]);
            cmp("busy at load", {23'h0, busy}, 24'h000000);
        end
    end
    initial begin
        #20000;
        err_total++;
        conclude();
    end
    initial begin
        repeat (6) @(posedge I_CLK);
        I_RST <= 1'b0;
        @(posedge I_CLK);
        #1;
        cmp("reset counter", pc, 24'h000000);
        cmp("reset read", {22'h0, rreq, busy}, 24'h000000);
        @(posedge I_CLK);
        adv <= 1'b1;
        npc <= 24'($random(seed));
        @(posedge I_CLK);
        adv <= 1'b0;
        @(posedge I_CLK);
        #1;
        cmp("advance", pc, npc);
        for (int i = 0; i < 30; i++) begin
            w = (i < 4) ? (i == 0 ? 0 : i == 1 ? 4 : i == 2 ? 5 : 122)
                : $unsigned($random(seed)) % 123;
            p = {$random(seed), $random(seed), $random(seed), $random(seed)};
            p = ((p >> (w + 1)) << (w + 1)) | (128'h1 << w);
            @(posedge I_CLK);
            trap <= p[4:0];
            irq <= p[122:5];
            alt <= i[0] ^ (i > 8);
            dly <= 2'($random(seed));
            acc <= 1'b1;
            ea = ((i[0] ^ (i > 8)) ? 24'h000100 : 24'h000000)
                + ((w < 5) ? 24'(6 + 2 * w) : 24'(20 + 2 * (w - 5)));
            notes.push_back({w[6:0], ea, ea ^ 24'hC3C3C3});
            @(posedge I_CLK);
            acc <= 1'b0;
            #1;
            k = 0;
            while (taken !== 1'b1 && k < 12) begin
                @(posedge I_CLK);
                #1;
                k++;
            end
            if (k >= 12) err_total++;
        end
        @(posedge I_CLK);
        #1;
        cmp("pending notes", 24'(notes.size()), 24'h000000);
        // second reset in mid-run, counter now holds a handler address
        @(posedge I_CLK);
        I_RST <= 1'b1;
        @(posedge I_CLK);
        I_RST <= 1'b0;
        @(posedge I_CLK);
        #1;
        cmp("second reset counter", pc, 24'h000000);
        cmp("second reset read", {22'h0, rreq, busy}, 24'h000000);
        conclude();
    end
endmodule // testbench

//--- verif/vector_memory.sv
// program memory model answering vector word reads
// assumes one-cycle read requests; answer delay set by the bench
`timescale 1ns/10ps
module vector_memory (
    input wire logic i_clk,
    input wire logic i_req,
    input wire logic [23:0] i_addr,
    input wire logic [1:0] i_delay,
    output logic o_valid,
    output logic [23:0] o_data
);
    logic [23:0] word = 24'h000000;
    initial o_valid = 1'b0;
    initial o_data = 24'hFFFFFF;
    always @(posedge i_clk) begin
        if (i_req) begin
            repeat (i_delay) @(posedge i_clk);
            word = i_addr ^ 24'hC3C3C3;
            o_valid <= 1'b1;
            o_data <= word;
            @(posedge i_clk);
            o_valid <= 1'b0;
            o_data <= ~word;
        end
    end
endmodule // vector_memory
